/* File: core/usd_pkg.sv */
// Constants and carriers for the shadow receive/transmit data port.
// Assumes a plain single-cycle register port and an external serializer.
package usd_pkg;
  localparam int          ADDR_W          = 32;
  localparam int          DEPTH           = 16;
  localparam int          PTR_W           = 4;
  localparam int          CNT_W           = 5;
  // Sixteen word aliases; printed offsets are multiples of four
  localparam logic [31:0] ALIAS_BASE      = 32'h50001130;
  localparam logic [31:0] ALIAS_LAST      = 32'h5000116C;
  localparam logic [31:0] ALIAS_12        = 32'h50001160;
  localparam logic [31:0] ALIAS_13        = 32'h50001164;
  localparam logic [31:0] CTRL_OFF        = 32'h50001180;
  localparam logic [31:0] LSR_OFF         = 32'h50001184;
  localparam logic [31:0] INT_STAT_OFF    = 32'h50001188;
  localparam logic [31:0] INT_MASK_OFF    = 32'h5000118C;
  // Control fields
  localparam int          CTRL_FIFO_EN    = 0;
  localparam int          CTRL_IR_MODE    = 1;
  // Line status fields
  localparam int          LSR_DR          = 0;
  localparam int          LSR_OE          = 1;
  localparam int          LSR_TX_HOLDING_EMPTY        = 5;
  // Interrupt status fields
  localparam int          IRQ_RX          = 0;
  localparam int          IRQ_OVR         = 1;
  localparam int          IRQ_TXE         = 2;
  localparam int          IRQ_TXDROP      = 3;
  localparam logic [3:0]  MASK_RESET      = 4'h0;
  localparam logic [15:0] ALIAS_RESET     = 16'h0000;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } usd_byte_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } usd_bus_t;
endpackage : usd_pkg

/* File: core/usd_shadow_port.sv */
// Shadow receive buffer / transmit holding data path with FIFOs.
// Assumes external deserializers deliver received bytes as pulses and an
// external serializer takes bytes with a valid/ready handshake.
`timescale 1ns/100ps

// Overview of operation
// - Sixteen word aliases all reach the same receive and transmit path.
// - Low byte read returns byte from serial input or infrared input by mode.
// - FIFOs off: unread byte overwritten by next one, overrun flagged.
// - FIFOs on: alias read returns the oldest receive FIFO entry.
// - Receive FIFO full: keep entries, drop new byte, flag overrun.
// - FIFOs off: one write clears the transmit-holding-empty flag.
// - FIFOs off: further writes overwrite the held character.
// - FIFOs on: sixteen characters accepted before transmit FIFO is full.
// - Write to full transmit FIFO is discarded.
// - Infrared mode sends characters on the active-low infrared output.
// - Normal mode sends characters on the plain serial output.
module usd_shadow_port (
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire usd_pkg::usd_bus_t i_bus,
  output logic [31:0]            o_rdata,
  input  wire usd_pkg::usd_byte_t i_rx_serial,
  input  wire usd_pkg::usd_byte_t i_rx_ir,
  output usd_pkg::usd_byte_t     o_tx_serial,
  output usd_pkg::usd_byte_t     o_tx_ir_n,
  input  wire logic              i_tx_ready,
  output logic                   o_irq
);
  import usd_pkg::*;

  logic [7:0]       rx_mem [DEPTH];
  logic [7:0]       tx_mem [DEPTH];
  logic [PTR_W-1:0] rx_rd, rx_wr, tx_rd, tx_wr;
  logic [CNT_W-1:0] rx_cnt, tx_cnt;
  logic [1:0]       ctrl;
  logic             overrun;
  logic [3:0]       int_stat, int_mask;
  logic             alias_hit, rx_pop, tx_push, tx_pop, tx_drop, rx_in, rx_drop;
  logic [7:0]       rx_byte;
  logic [CNT_W-1:0] rx_cap, tx_cap;
  logic             tx_valid, tx_holding_empty, ovr_evt;
  logic             prev_tx_holding_empty;

  // Alias window decode, word aligned
  assign alias_hit = (i_bus.addr >= ALIAS_BASE) && (i_bus.addr <= ALIAS_LAST)
                     && (i_bus.addr[1:0] == 2'b00);
  // Source select by mode
  assign rx_in   = ctrl[CTRL_IR_MODE] ? i_rx_ir.valid : i_rx_serial.valid;
  assign rx_byte = ctrl[CTRL_IR_MODE] ? i_rx_ir.data  : i_rx_serial.data;
  // Capacity is one entry with FIFOs off, full depth with FIFOs on
  assign rx_cap  = ctrl[CTRL_FIFO_EN] ? CNT_W'(DEPTH) : CNT_W'(1);
  assign tx_cap  = ctrl[CTRL_FIFO_EN] ? CNT_W'(DEPTH) : CNT_W'(1);
  assign rx_pop  = i_bus.rd && alias_hit && (rx_cnt != '0);
  assign rx_drop = rx_in && (rx_cnt == rx_cap) && !rx_pop && ctrl[CTRL_FIFO_EN];
  assign ovr_evt = rx_in && (rx_cnt == rx_cap) && !rx_pop;
  assign tx_valid = (tx_cnt != '0);
  assign tx_pop  = tx_valid && i_tx_ready;
  assign tx_push = i_bus.wr && alias_hit;
  assign tx_drop = tx_push && ctrl[CTRL_FIFO_EN] && (tx_cnt == tx_cap) && !tx_pop;
  assign tx_holding_empty    = (tx_cnt == '0);

  // Receive storage and pointers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_rd  <= '0;
      rx_wr  <= '0;
      rx_cnt <= '0;
    end else begin
      if (rx_in && !ctrl[CTRL_FIFO_EN]) begin
        rx_mem[0] <= rx_byte;
        rx_rd     <= '0;
        rx_wr     <= '0;
        rx_cnt    <= CNT_W'(1);
      end else if (rx_pop && !ctrl[CTRL_FIFO_EN]) begin
        rx_cnt <= '0; // Read empties the single buffer
      end else begin
        if (rx_in && !rx_drop) begin
          rx_mem[rx_wr] <= rx_byte;
          rx_wr         <= rx_wr + PTR_W'(1);
        end
        if (rx_pop) begin
          rx_rd <= rx_rd + PTR_W'(1);
        end
        rx_cnt <= rx_cnt + CNT_W'(rx_in && !rx_drop) - CNT_W'(rx_pop);
      end
    end
  end

  // Transmit storage and pointers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_rd  <= '0;
      tx_wr  <= '0;
      tx_cnt <= '0;
    end else if (!ctrl[CTRL_FIFO_EN]) begin
      if (tx_push) begin
        tx_mem[0] <= i_bus.wdata[7:0];
        tx_cnt    <= CNT_W'(1);
      end else if (tx_pop) begin
        tx_cnt <= '0;
      end
      tx_rd <= '0;
      tx_wr <= '0;
    end else begin
      if (tx_push && !tx_drop) begin
        tx_mem[tx_wr] <= i_bus.wdata[7:0];
        tx_wr         <= tx_wr + PTR_W'(1);
      end
      if (tx_pop) begin
        tx_rd <= tx_rd + PTR_W'(1);
      end
      tx_cnt <= tx_cnt + CNT_W'(tx_push && !tx_drop) - CNT_W'(tx_pop);
    end
  end

  // Outbound byte steered by mode; data from flip-flops
  always_comb begin
    o_tx_serial.valid = tx_valid && !ctrl[CTRL_IR_MODE];
    o_tx_serial.data  = tx_mem[tx_rd];
    o_tx_ir_n.valid   = tx_valid && ctrl[CTRL_IR_MODE];
    o_tx_ir_n.data    = ~tx_mem[tx_rd];
  end

  // Control register and overrun flag
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl    <= 2'h0;
      overrun <= 1'b0;
    end else begin
      if (i_bus.wr && i_bus.addr == CTRL_OFF) begin
        ctrl <= i_bus.wdata[1:0];
      end
      if (ovr_evt) begin
        overrun <= 1'b1;
      end else if (i_bus.rd && i_bus.addr == LSR_OFF) begin
        overrun <= 1'b0;
      end
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      int_stat  <= 4'h0;
      int_mask  <= MASK_RESET;
      prev_tx_holding_empty <= 1'b1;
    end else begin
      prev_tx_holding_empty <= tx_holding_empty;
      if (i_bus.wr && i_bus.addr == INT_MASK_OFF) begin
        int_mask <= i_bus.wdata[3:0];
      end
      int_stat <= (int_stat & ~((i_bus.wr && i_bus.addr == INT_STAT_OFF)
                  ? i_bus.wdata[3:0] : 4'h0))
                | {tx_drop, tx_holding_empty && !prev_tx_holding_empty, ovr_evt, rx_in};
    end
  end

  assign o_irq = |(int_stat & int_mask);

  // Read data, one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= 32'h0;
    end else if (i_bus.rd) begin
      if (alias_hit) begin
        o_rdata <= {16'h0, 8'h00, rx_mem[rx_rd]};
      end else begin
        case (i_bus.addr)
          CTRL_OFF:     o_rdata <= {30'h0, ctrl};
          LSR_OFF:      o_rdata <= {26'h0, tx_holding_empty, 3'h0, overrun || ovr_evt,
                                    rx_cnt != '0};
          INT_STAT_OFF: o_rdata <= {28'h0, int_stat};
          INT_MASK_OFF: o_rdata <= {28'h0, int_mask};
          default:      o_rdata <= 32'h0;
        endcase
      end
    end else begin
      o_rdata <= 32'h0;
    end
  end

  // Checks
  property p_ovr_flag;
    @(posedge i_clk) disable iff (i_reset) ovr_evt |=> overrun;
  endproperty
  a_ovr_flag: assert property (p_ovr_flag) else $error("overrun not flagged");

  property p_rx_keep;
    @(posedge i_clk) disable iff (i_reset) rx_drop |=> $stable(rx_wr);
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("full fifo overwritten");

  property p_tx_holding_empty_clr;
    @(posedge i_clk) disable iff (i_reset)
      (tx_push && !ctrl[CTRL_FIFO_EN]) |=> !tx_holding_empty;
  endproperty
  a_tx_holding_empty_clr: assert property (p_tx_holding_empty_clr) else $error("holding empty not cleared");

  property p_tx_cap;
    @(posedge i_clk) disable iff (i_reset) tx_cnt <= CNT_W'(DEPTH);
  endproperty
  a_tx_cap: assert property (p_tx_cap) else $error("transmit fifo over depth");

  property p_tx_drop;
    @(posedge i_clk) disable iff (i_reset) tx_drop |=> $stable(tx_wr);
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("full write queued");

  property p_rsv_zero;
    @(posedge i_clk) disable iff (i_reset) $past(i_bus.rd && alias_hit) |-> o_rdata[15:8] == 8'h00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits nonzero");

  property p_ir_route;
    @(posedge i_clk) disable iff (i_reset) ctrl[CTRL_IR_MODE] |-> !o_tx_serial.valid;
  endproperty
  a_ir_route: assert property (p_ir_route) else $error("serial used in ir mode");

  property p_ser_route;
    @(posedge i_clk) disable iff (i_reset) !ctrl[CTRL_IR_MODE] |-> !o_tx_ir_n.valid;
  endproperty
  a_ser_route: assert property (p_ser_route) else $error("ir used in serial mode");

  // Alias read and write strobes
  sequence s_alias_rd;
    i_bus.rd && alias_hit;
  endsequence
  sequence s_alias_wr;
    i_bus.wr && alias_hit;
  endsequence

  // Alias read returns the head byte
  property p_rdata_alias;
    @(posedge i_clk) disable iff (i_reset)
      s_alias_rd |=> o_rdata[7:0] == $past(rx_mem[rx_rd]);
  endproperty
  a_rdata_alias: assert property (p_rdata_alias) else $error("alias read wrong byte");

  // Infrared byte lands in the single buffer
  property p_src_ir;
    @(posedge i_clk) disable iff (i_reset)
      (ctrl == 2'h2 && i_rx_ir.valid) |=> rx_mem[0] == $past(i_rx_ir.data);
  endproperty
  a_src_ir: assert property (p_src_ir) else $error("infrared byte not taken");

  // Serial byte lands in the single buffer
  property p_src_ser;
    @(posedge i_clk) disable iff (i_reset)
      (ctrl == 2'h0 && i_rx_serial.valid) |=> rx_mem[0] == $past(i_rx_serial.data);
  endproperty
  a_src_ser: assert property (p_src_ser) else $error("serial byte not taken");

  // Single buffer: new byte replaces the old one
  property p_rx_over;
    @(posedge i_clk) disable iff (i_reset)
      (rx_in && !ctrl[CTRL_FIFO_EN]) |=> rx_cnt == CNT_W'(1);
  endproperty
  a_rx_over: assert property (p_rx_over) else $error("single buffer not refilled");

  // Single buffer: a read empties it
  property p_rd_pop;
    @(posedge i_clk) disable iff (i_reset)
      (i_bus.rd && alias_hit && rx_cnt != '0 && !rx_in && !ctrl[CTRL_FIFO_EN])
      |=> rx_cnt == '0;
  endproperty
  a_rd_pop: assert property (p_rd_pop) else $error("read left data ready");

  // Overrun raises its sticky status bit
  property p_ovr_stat;
    @(posedge i_clk) disable iff (i_reset) ovr_evt |=> int_stat[IRQ_OVR];
  endproperty
  a_ovr_stat: assert property (p_ovr_stat) else $error("overrun status not set");

  // Status read clears overrun when no new one
  property p_oe_clr;
    @(posedge i_clk) disable iff (i_reset)
      (i_bus.rd && i_bus.addr == LSR_OFF && !ovr_evt) |=> !overrun;
  endproperty
  a_oe_clr: assert property (p_oe_clr) else $error("overrun not cleared");

  // Receive fifo grows by one on a kept byte
  property p_rx_inc;
    @(posedge i_clk) disable iff (i_reset)
      (ctrl[CTRL_FIFO_EN] && rx_in && !rx_drop && !rx_pop)
      |=> rx_cnt == $past(rx_cnt) + CNT_W'(1);
  endproperty
  a_rx_inc: assert property (p_rx_inc) else $error("receive fifo not grown");

  // Head advances on each fifo read
  property p_rx_adv;
    @(posedge i_clk) disable iff (i_reset)
      (rx_pop && ctrl[CTRL_FIFO_EN]) |=> rx_rd == $past(rx_rd) + PTR_W'(1);
  endproperty
  a_rx_adv: assert property (p_rx_adv) else $error("receive head stuck");

  // Receive count never above depth
  property p_rx_cap;
    @(posedge i_clk) disable iff (i_reset) rx_cnt <= CNT_W'(DEPTH);
  endproperty
  a_rx_cap: assert property (p_rx_cap) else $error("receive fifo over depth");

  // Dropped byte leaves the count alone
  property p_rx_drop_cnt;
    @(posedge i_clk) disable iff (i_reset) rx_drop |=> rx_cnt == $past(rx_cnt);
  endproperty
  a_rx_drop_cnt: assert property (p_rx_drop_cnt) else $error("dropped byte counted");

  // Holding byte takes the written value
  property p_tx_hold;
    @(posedge i_clk) disable iff (i_reset)
      (s_alias_wr ##0 !ctrl[CTRL_FIFO_EN]) |=> tx_mem[0] == $past(i_bus.wdata[7:0]);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("holding byte not written");

  // Last byte sent sets holding empty
  property p_tx_holding_empty_set;
    @(posedge i_clk) disable iff (i_reset)
      (tx_pop && tx_cnt == CNT_W'(1) && !tx_push) |=> tx_holding_empty;
  endproperty
  a_tx_holding_empty_set: assert property (p_tx_holding_empty_set) else $error("holding empty not set");

  // Transmit fifo grows by one on a kept write
  property p_tx_inc;
    @(posedge i_clk) disable iff (i_reset)
      (ctrl[CTRL_FIFO_EN] && tx_push && !tx_drop && !tx_pop)
      |=> tx_cnt == $past(tx_cnt) + CNT_W'(1);
  endproperty
  a_tx_inc: assert property (p_tx_inc) else $error("transmit fifo not grown");

  // Dropped write leaves the count alone
  property p_tx_drop_cnt;
    @(posedge i_clk) disable iff (i_reset) tx_drop |=> tx_cnt == $past(tx_cnt);
  endproperty
  a_tx_drop_cnt: assert property (p_tx_drop_cnt) else $error("dropped write counted");

  // Serial byte stands until taken
  property p_ser_stand;
    @(posedge i_clk) disable iff (i_reset)
      (o_tx_serial.valid && !i_tx_ready && !i_bus.wr) |=> $stable(o_tx_serial);
  endproperty
  a_ser_stand: assert property (p_ser_stand) else $error("serial byte lost");

  // Infrared byte stands until taken
  property p_ir_stand;
    @(posedge i_clk) disable iff (i_reset)
      (o_tx_ir_n.valid && !i_tx_ready && !i_bus.wr) |=> $stable(o_tx_ir_n);
  endproperty
  a_ir_stand: assert property (p_ir_stand) else $error("infrared byte lost");
endmodule : usd_shadow_port

/* File: tb/usd_line_model.sv */
// Remote line transceiver: sends received bytes, takes sent bytes.
// Assumes the data port's byte pulses and its ready handshake.
`timescale 1ns/100ps
module usd_line_model (
  input  wire logic               i_clk,
  input  wire logic               i_stall,
  input  wire usd_pkg::usd_byte_t i_tx_serial,
  input  wire usd_pkg::usd_byte_t i_tx_ir_n,
  output logic                    o_ready,
  output usd_pkg::usd_byte_t      o_rx_serial,
  output usd_pkg::usd_byte_t      o_rx_ir
);
  import usd_pkg::*;
  int         seed = 32'hB4D7;
  logic [7:0] got[$];
  initial begin
    o_ready = 1'b0;
    o_rx_serial = '0;
    o_rx_ir = '0;
  end
  // Random ready unless stalled; infrared bytes stored true
  always @(posedge i_clk) begin
    if (o_ready && i_tx_serial.valid) got.push_back(i_tx_serial.data);
    if (o_ready && i_tx_ir_n.valid) got.push_back(~i_tx_ir_n.data);
    o_ready <= !i_stall && 1'($random(seed));
  end
  // One-cycle byte pulse; idle data shows the inverse
  task automatic send(input logic ir, input logic [7:0] d);
    @(posedge i_clk);
    if (ir) o_rx_ir <= '{1'b1, d};
    else o_rx_serial <= '{1'b1, d};
    @(posedge i_clk);
    o_rx_ir <= '{1'b0, ~d};
    o_rx_serial <= '{1'b0, ~d};
  endtask : send
endmodule : usd_line_model

/* File: tb/tb_uart_shadow_data_port.sv */
// Self-checking bench for the shadow data port.
// Assumes the line model and a 250 MHz clock.
`timescale 1ns/100ps
module tb_uart_shadow_data_port;
  import usd_pkg::*;
  logic        i_clk, i_reset, o_irq, stall, ready;
  usd_bus_t    bus;
  logic [31:0] o_rdata, rd_val;
  usd_byte_t   rx_s, rx_i, tx_s, tx_i;
  int          errors, checks_done, cyc, seed;
  logic [7:0]  b, exp_q[$];
  usd_shadow_port dut (.i_clk(i_clk), .i_reset(i_reset), .i_bus(bus), .o_rdata(o_rdata),
    .i_rx_serial(rx_s), .i_rx_ir(rx_i), .o_tx_serial(tx_s), .o_tx_ir_n(tx_i),
    .i_tx_ready(ready), .o_irq(o_irq));
  usd_line_model line (.i_clk(i_clk), .i_stall(stall), .i_tx_serial(tx_s),
    .i_tx_ir_n(tx_i), .o_ready(ready), .o_rx_serial(rx_s), .o_rx_ir(rx_i));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // Expected line status view: ready, overrun, holding empty
  function automatic logic [31:0] lsr_exp(input logic dr, oe, tx_holding_empty);
    return {26'h0, tx_holding_empty, 3'h0, oe, dr};
  endfunction : lsr_exp
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge i_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask : rd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Let the line take n bytes, bounded
  task automatic drain(input int n);
    stall <= 1'b0;
    for (int i = 0; i < 300 && line.got.size() < n; i++) @(posedge i_clk);
    chk("tx_count", n, line.got.size());
    stall <= 1'b1;
  endtask : drain
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // Hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    seed = 32'hB4D7;
    i_reset = 1'b1;
    stall = 1'b1;
    bus = '0;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(ALIAS_12);
    chk("alias12", {16'h0, ALIAS_RESET}, rd_val);
    rd(32'h50001190);
    chk("unmapped", 32'h0, rd_val);
    rd(LSR_OFF);
    chk("lsr_rst", lsr_exp(0, 0, 1), rd_val & 32'h23);
    $display("test reset done");
    b = 8'($random(seed));
    line.send(1'b0, b);
    line.send(1'b0, b + 8'h1);
    rd(LSR_OFF);
    chk("lsr_ovr", lsr_exp(1, 1, 1), rd_val & 32'h23);
    rd(ALIAS_13);
    chk("rx_last", {24'h0, b + 8'h1}, rd_val);
    wr(INT_MASK_OFF, 32'h2);
    repeat (2) @(posedge i_clk);
    chk("irq_on", 1, o_irq);
    wr(INT_STAT_OFF, 32'hF);
    line.send(1'b0, b);
    repeat (2) @(posedge i_clk);
    chk("irq_masked", 0, o_irq);
    rd(ALIAS_12);
    $display("test rx single done");
    wr(CTRL_OFF, 32'h3);
    line.send(1'b0, 8'h5A);
    for (int i = 0; i < 17; i++) begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      line.send(1'b1, b);
    end
    for (int i = 0; i < 16; i++) begin
      rd(ALIAS_BASE + 32'(4 * i));
      chk("rx_fifo", {24'h0, exp_q[i]}, rd_val);
    end
    rd(LSR_OFF);
    chk("lsr_full", lsr_exp(0, 1, 1), rd_val & 32'h23);
    $display("test rx fifo done");
    wr(CTRL_OFF, 32'h0);
    rd(LSR_OFF);
    chk("tx_holding_empty_set", lsr_exp(0, 0, 1), rd_val & 32'h23);
    wr(ALIAS_12, 32'h0000FF11);
    wr(ALIAS_13, 32'h0000FF22);
    rd(LSR_OFF);
    chk("tx_holding_empty_clr", lsr_exp(0, 0, 0), rd_val & 32'h23);
    chk("tx_hold", {1'b1, 8'h22, 1'b0}, {tx_s, tx_i.valid});
    drain(1);
    chk("tx_sent", 8'h22, line.got[0]);
    line.got.delete();
    $display("test tx single done");
    wr(CTRL_OFF, 32'h3);
    exp_q.delete();
    for (int i = 0; i < 17; i++) begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      wr(ALIAS_BASE + 32'(4 * (i % 16)), {24'h0, b});
    end
    rd(INT_STAT_OFF);
    chk("tx_drop", 1, rd_val[IRQ_TXDROP]);
    chk("tx_ir", {1'b1, ~exp_q[0], 1'b0}, {tx_i, tx_s.valid});
    drain(16);
    for (int i = 0; i < 16; i++) chk("tx_fifo", exp_q[i], line.got[i]);
    $display("test tx fifo done");
    report_and_stop();
  end
endmodule : tb_uart_shadow_data_port
